/* File: logic/flash_host.sv */
// flash_host: serial bus master for a page-organised serial flash
// assumes flash pins wired directly; miso arrives asynchronously
`timescale 1ns/1ns
module flash_host
   import flash_host_pkg::*;
(
   // system clock and reset
   input  wire logic        CLK_SYS,
   input  wire logic        RST,
   // command request
   input  wire logic        CMD_VALID,
   output logic             CMD_READY,
   input  wire logic [7:0]  CMD_OPCODE,
   input  wire logic [23:0] CMD_ADDR,
   input  wire logic [1:0]  CMD_NADDR,
   input  wire logic [2:0]  CMD_NDUMMY,
   input  wire logic [15:0] CMD_NWRITE,
   input  wire logic [15:0] CMD_NREAD,
   input  wire logic        CMD_MODE3,
   input  wire logic        CMD_PROG,
   input  wire logic        CMD_REWRITE,
   input  wire logic        PAGE_528,
   // write data stream
   input  wire logic        WR_VALID,
   output logic             WR_READY,
   input  wire logic [7:0]  WR_DATA,
   // read data stream
   output logic             RD_VALID,
   input  wire logic        RD_READY,
   output logic [7:0]       RD_DATA,
   // wear upkeep
   output logic             REWRITE_DUE,
   // flash pins
   output logic             FLASH_CS_N,
   output logic             FLASH_SCK,
   output logic             FLASH_MOSI,
   input  wire logic        FLASH_MISO,
   output logic             FLASH_RESET_N
);
   typedef struct packed {
      state_t                  st;
      logic                    cs_n;
      logic                    sck;
      logic                    mosi;
      logic                    rst_n;
      logic                    cmd_rdy;
      logic                    wr_rdy;
      logic [11:0]             tcnt;
      logic [2:0]              div;
      logic                    mode3;
      logic                    slow;
      logic                    started;
      logic                    tx_done;
      logic                    rx_arm;
      logic                    rx_pend;
      logic                    wr_have;
      logic [7:0]              opc;
      logic [7:0]              tx_sr;
      logic [7:0]              rx_sr;
      logic [7:0]              rx_byte;
      logic [7:0]              wr_buf;
      logic [23:0]             addr;
      logic [1:0]              naddr;
      logic [2:0]              ndum;
      logic [2:0]              tbit;
      logic [2:0]              rbit;
      logic [15:0]             nwr;
      logic [15:0]             nfetch;
      logic [15:0]             nrd;
      logic [PAGE_PTR_W-1:0]   ptr;
      logic [15:0]             ops;
      logic                    due;
      logic [1:0]              miso_s;
   } host_t;

   host_t      q;
   host_t      d;
   logic       tick;
   logic       stall;
   logic       fifo_rdy;
   logic [1:0] cls;
   logic [4:0] ash;

   // opcode classes: bit 1 slow clock, bit 0 no address field
   function automatic logic [1:0] op_class(input logic [7:0] op);
      case (op)
         OP_CAR_LEGACY, OP_CAR_FAST: op_class = 2'h0;
         OP_CAR_SLOW:                op_class = 2'h2;
         OP_PAGE_RD:                 op_class = 2'h0;
         OP_BUF1_FAST, OP_BUF2_FAST: op_class = 2'h0;
         OP_BUF1_SLOW, OP_BUF2_SLOW: op_class = 2'h2;
         OP_PROT_RD, OP_LOCK_RD:     op_class = 2'h0;
         OP_SEC_RD:                  op_class = 2'h0;
         OP_STATUS, OP_IDENT:        op_class = 2'h1;
         default:                    op_class = 2'h0;
      endcase
   endfunction : op_class

   // byte address of a page, laid out for the configured page size
   function automatic logic [23:0] page_addr(input logic [PAGE_PTR_W-1:0] p,
                                             input logic big);
      page_addr = 24'(p) << (big ? PAGE_SHIFT_528 : PAGE_SHIFT_512);
   endfunction : page_addr

   // outputs straight from state flops
   assign CMD_READY     = q.cmd_rdy;
   assign WR_READY      = q.wr_rdy;
   assign REWRITE_DUE   = q.due;
   assign FLASH_CS_N    = q.cs_n;
   assign FLASH_SCK     = q.sck;
   assign FLASH_MOSI    = q.mosi;
   assign FLASH_RESET_N = q.rst_n;

   // next state of the whole controller
   always_comb begin
      d        = q;
      cls      = op_class(CMD_OPCODE);
      ash      = {2'(2'h3 - CMD_NADDR), 3'h0};
      d.miso_s = {q.miso_s[0], FLASH_MISO};
      // hand a finished byte to the read buffer when it has room
      if (q.rx_pend && fifo_rdy) begin
         d.rx_pend = 1'b0;
      end
      // prefetch one write byte so the shifter never waits mid-byte
      if (WR_VALID && q.wr_rdy) begin
         d.wr_buf  = WR_DATA;
         d.wr_have = 1'b1;
         d.nfetch  = q.nfetch - 16'h1;
      end
      // clock divider: fast half period, or slow for low-rate reads
      tick  = q.div == 3'h0;
      d.div = tick ? (q.slow ? HALF_SLOW : HALF_FAST) - 3'h1 : q.div - 3'h1;
      // the clock only pauses low, where the device holds its output
      stall = q.rx_pend || (q.tbit == 3'h7 && !q.tx_done && q.naddr == 2'h0 &&
              q.ndum == 3'h0 && q.nwr != 16'h0 && !q.wr_have);
      unique case (q.st)
         S_RHOLD: begin
            // select stays high across the whole reset pulse
            d.rst_n = 1'b0;
            d.cs_n  = 1'b1;
            d.tcnt  = q.tcnt + 12'h1;
            if (q.tcnt == RST_CYC - 12'h1) begin
               d.st    = S_RREC;
               d.rst_n = 1'b1;
               d.tcnt  = '0;
            end
         end
         S_RREC: begin
            d.tcnt = q.tcnt + 12'h1;
            if (q.tcnt == REC_CYC - 12'h1) begin
               d.st      = S_IDLE;
               d.cmd_rdy = 1'b1;
            end
         end
         S_IDLE: begin
            if (CMD_VALID && q.cmd_rdy) begin
               d.cmd_rdy = 1'b0;
               d.st      = S_SETUP;
               d.tcnt    = '0;
               d.sck     = CMD_MODE3;
               d.mode3   = CMD_MODE3;
               d.slow    = cls[1];
               d.opc     = CMD_OPCODE;
               d.tx_sr   = CMD_OPCODE;
               d.naddr   = cls[0] ? 2'h0 : CMD_NADDR;
               d.addr    = CMD_ADDR << ash;
               d.ndum    = CMD_NDUMMY;
               d.nwr     = CMD_NWRITE;
               d.nfetch  = CMD_NWRITE;
               d.nrd     = CMD_NREAD;
               d.wr_have = 1'b0;
               d.tbit    = '0;
               d.rbit    = '0;
               d.started = 1'b0;
               d.tx_done = 1'b0;
               d.rx_arm  = 1'b0;
               // upkeep rewrite goes to the page under the pointer
               if (CMD_REWRITE) begin
                  d.naddr = 2'h3;
                  d.addr  = page_addr(q.ptr, PAGE_528);
                  d.ptr   = q.ptr + 1'b1;
                  d.ops   = '0;
                  d.due   = 1'b0;
               end
               // either program route counts toward the wear budget
               if (CMD_PROG && d.ops != 16'hffff) begin
                  d.ops = d.ops + 16'h1;
                  if (d.ops == REWRITE_SPACING) begin
                     d.due = 1'b1;
                  end
               end
            end
         end
         S_SETUP: begin
            d.tcnt = q.tcnt + 12'h1;
            if (q.tcnt == 12'h0) begin
               d.cs_n = 1'b0;
               d.mosi = q.opc[7];
            end
            if (q.tcnt == CSS_CYC) begin
               d.st  = S_RUN;
               d.div = (q.slow ? HALF_SLOW : HALF_FAST) - 3'h1;
            end
         end
         S_RUN: begin
            if (tick && !(stall && !q.sck)) begin
               d.sck = !q.sck;
               if (!q.sck) begin
                  // rising edge: device takes the bit, host launches the next
                  d.started = 1'b1;
                  if (!q.tx_done) begin
                     if (q.tbit != 3'h7) begin
                        d.tx_sr = q.tx_sr << 1;
                        d.tbit  = q.tbit + 3'h1;
                     end else begin
                        d.tbit = '0;
                        if (q.naddr != 2'h0) begin
                           d.tx_sr = q.addr[23:16];
                           d.addr  = q.addr << 8;
                           d.naddr = q.naddr - 2'h1;
                        end else if (q.ndum != 3'h0) begin
                           d.tx_sr = '0;
                           d.ndum  = q.ndum - 3'h1;
                        end else if (q.nwr != 16'h0) begin
                           d.tx_sr   = q.wr_buf;
                           d.wr_have = 1'b0;
                           d.nwr     = q.nwr - 16'h1;
                        end else begin
                           d.tx_done = 1'b1;
                        end
                     end
                     d.mosi = d.tx_done ? 1'b0 : d.tx_sr[7];
                  end
               end else if (q.started && q.tx_done) begin
                  // falling edge: first one after the command only arms capture
                  if (!q.rx_arm) begin
                     d.rx_arm = 1'b1;
                     if (q.nrd == 16'h0) begin
                        d.st   = S_HOLD;
                        d.tcnt = '0;
                     end
                  end else begin
                     // bit launched one fall earlier, so timing is full-cycle
                     d.rx_sr = {q.rx_sr[6:0], q.miso_s[1]};
                     d.rbit  = q.rbit + 3'h1;
                     if (q.rbit == 3'h7) begin
                        d.rx_byte = d.rx_sr;
                        d.rx_pend = 1'b1;
                        d.nrd     = q.nrd - 16'h1;
                        if (q.nrd == 16'h1) begin
                           d.st   = S_HOLD;
                           d.tcnt = '0;
                        end
                     end
                  end
               end
            end
         end
         S_HOLD: begin
            d.tcnt = q.tcnt + 12'h1;
            if (q.tcnt >= CSH_CYC - 12'h1 && !q.rx_pend) begin
               d.cs_n = 1'b1;
               d.st   = S_DESEL;
               d.tcnt = '0;
            end
         end
         S_DESEL: begin
            // clock returns to its idle level only once deselected
            d.sck  = q.mode3;
            d.tcnt = q.tcnt + 12'h1;
            if (q.tcnt == CS_CYC - 12'h1) begin
               d.st      = S_IDLE;
               d.cmd_rdy = 1'b1;
            end
         end
      endcase
      d.wr_rdy = (d.st == S_SETUP || d.st == S_RUN) && !d.wr_have && d.nfetch != 16'h0;
   end

   // state register; reset holds the flash in reset, deselected
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         q      <= '0;
         q.cs_n <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // read data buffer; a full buffer stalls the serial clock
   byte_fifo #(
      .W     (BYTE_W),
      .DEPTH (FIFO_DEPTH)
   ) u_rd_fifo (
      .clk       (CLK_SYS),
      .rst       (RST),
      .in_valid  (q.rx_pend),
      .in_ready  (fifo_rdy),
      .in_data   (q.rx_byte),
      .out_valid (RD_VALID),
      .out_ready (RD_READY),
      .out_data  (RD_DATA)
   );

   // checks on the pin sequence
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (RST);

   chk_cs_before_rst: assert property (
      $rose(FLASH_RESET_N) |-> FLASH_CS_N && $past(FLASH_CS_N))
      else $error("select low at reset release");
   chk_sck_half_min: assert property (
      $changed(FLASH_SCK) && !FLASH_CS_N |-> $past(FLASH_SCK, 2) == $past(FLASH_SCK, 1))
      else $error("clock half period too short");
   chk_slow_half: assert property (
      $changed(FLASH_SCK) && !FLASH_CS_N && q.slow |->
         $past(FLASH_SCK, 4) == $past(FLASH_SCK, 1) && $past(FLASH_SCK, 3) == $past(FLASH_SCK, 1))
      else $error("slow read clock too fast");
   chk_cs_setup_time: assert property (
      $fell(FLASH_CS_N) |-> ##1 $stable(FLASH_SCK) ##1 $stable(FLASH_SCK))
      else $error("clock moved inside select setup");
   chk_launch_rise: assert property (
      !FLASH_CS_N && $past(!FLASH_CS_N) && $changed(FLASH_MOSI) |-> $rose(FLASH_SCK))
      else $error("data launched off the rising edge");
   chk_msb_first: assert property (
      $fell(FLASH_CS_N) |-> FLASH_MOSI == q.opc[7])
      else $error("first bit is not opcode bit 7");
   chk_sample_on_fall: assert property (
      !FLASH_CS_N && $changed(q.rbit) |-> $fell(FLASH_SCK))
      else $error("response sampled off the falling edge");
   chk_rx_after_tx: assert property (
      !FLASH_CS_N && $changed(q.rbit) |-> q.tx_done && $past(q.rx_arm))
      else $error("response sampled before command ended");
   chk_no_addr_bytes: assert property (
      q.st == S_RUN && (q.opc == OP_STATUS || q.opc == OP_IDENT) |-> q.naddr == 2'h0)
      else $error("address sent with status or id read");
   chk_rewrite_addr: assert property (
      CMD_VALID && CMD_READY && CMD_REWRITE |=>
         q.addr == page_addr($past(q.ptr), $past(PAGE_528)) && q.ptr == $past(q.ptr) + 1'b1)
      else $error("rewrite not at page pointer");
   chk_due_count: assert property (
      $rose(REWRITE_DUE) |-> q.ops == REWRITE_SPACING)
      else $error("rewrite due raised at wrong count");

   cov_mode3_cmd:  cover property ($fell(FLASH_CS_N) && q.mode3);
   cov_fifo_stall: cover property (q.rx_pend && !fifo_rdy);
   cov_write_wait: cover property (q.st == S_RUN && stall && !q.rx_pend);
   cov_due:        cover property ($rose(REWRITE_DUE));
endmodule : flash_host

/* File: logic/flash_host_pkg.sv */
// flash_host_pkg: constants shared by the serial flash host controller
// assumes a 250 MHz system clock and one flash device on the pins
package flash_host_pkg;
   // clock rates
   localparam int CLK_NS       = 4;
   localparam int CLK_MHZ      = 250;
   localparam int SCK_FAST_MHZ = 66;
   localparam int SCK_SLOW_MHZ = 33;
   localparam logic [2:0] HALF_FAST =
      3'((CLK_MHZ + 2 * SCK_FAST_MHZ - 1) / (2 * SCK_FAST_MHZ));
   localparam logic [2:0] HALF_SLOW =
      3'((CLK_MHZ + 2 * SCK_SLOW_MHZ - 1) / (2 * SCK_SLOW_MHZ));
   // pin timing, least times rounded up to whole cycles
   localparam int T_CSS_NS = 5;
   localparam int T_CSH_NS = 5;
   localparam int T_CS_NS  = 50;
   localparam int T_RST_NS = 10000;
   localparam int T_REC_NS = 1000;
   localparam logic [11:0] CSS_CYC = 12'((T_CSS_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [11:0] CSH_CYC = 12'((T_CSH_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [11:0] CS_CYC  = 12'((T_CS_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [11:0] RST_CYC = 12'((T_RST_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [11:0] REC_CYC = 12'((T_REC_NS + CLK_NS - 1) / CLK_NS);
   // wear upkeep
   localparam int REWRITE_OPS  = 10000;
   localparam int SECTOR_PAGES = 128;
   localparam logic [15:0] REWRITE_SPACING = 16'(REWRITE_OPS / SECTOR_PAGES);
   localparam int PAGE_PTR_W     = 13;
   localparam int PAGE_SHIFT_512 = 9;
   localparam int PAGE_SHIFT_528 = 10;
   // read data buffer
   localparam int BYTE_W     = 8;
   localparam int FIFO_DEPTH = 32;
   // opcodes
   localparam logic [7:0] OP_CAR_LEGACY = 8'he8;
   localparam logic [7:0] OP_CAR_FAST   = 8'h0b;
   localparam logic [7:0] OP_CAR_SLOW   = 8'h03;
   localparam logic [7:0] OP_PAGE_RD    = 8'hd2;
   localparam logic [7:0] OP_BUF1_FAST  = 8'hd4;
   localparam logic [7:0] OP_BUF2_FAST  = 8'hd6;
   localparam logic [7:0] OP_BUF1_SLOW  = 8'hd1;
   localparam logic [7:0] OP_BUF2_SLOW  = 8'hd3;
   localparam logic [7:0] OP_PROT_RD    = 8'h32;
   localparam logic [7:0] OP_LOCK_RD    = 8'h35;
   localparam logic [7:0] OP_SEC_RD     = 8'h77;
   localparam logic [7:0] OP_STATUS     = 8'hd7;
   localparam logic [7:0] OP_IDENT      = 8'h9f;
   // controller states
   typedef enum logic [2:0] {
      S_RHOLD, S_RREC, S_IDLE, S_SETUP, S_RUN, S_HOLD, S_DESEL
   } state_t;
endpackage : flash_host_pkg

/* File: logic/byte_fifo.sv */
// byte_fifo: first-in first-out buffer with registered output
// assumes both sides on one clock; output stage adds one word of room
`timescale 1ns/1ns
module byte_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 32
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // filling side
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // draining side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0]           wp;
      logic [AW-1:0]           rp;
      logic [AW:0]             cnt;
      logic                    ov;
      logic [W-1:0]            od;
   } fifo_t;

   fifo_t q;
   fifo_t d;
   logic  push;
   logic  pop;

   // full is honest: ready drops once the store holds depth words
   assign in_ready  = q.cnt != (AW + 1)'(DEPTH);
   assign out_valid = q.ov;
   assign out_data  = q.od;

   // next state: store on push, refill the output stage on pop
   always_comb begin
      d    = q;
      push = in_valid && in_ready;
      pop  = (q.cnt != '0) && (!q.ov || out_ready);
      if (out_ready) begin
         d.ov = 1'b0;
      end
      if (push) begin
         d.mem[q.wp] = in_data;
         d.wp        = q.wp + 1'b1;
      end
      if (pop) begin
         d.od = q.mem[q.rp];
         d.ov = 1'b1;
         d.rp = q.rp + 1'b1;
      end
      d.cnt = q.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
   end

   // state register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule : byte_fifo

/* File: tb/flash_model.sv */
// flash_model: behavioural serial flash answering every opcode
// assumes select low frames a transfer and the host launches on rise
`timescale 1ns/1ns
module flash_model (
   // flash pins
   input  wire logic   cs_n,
   input  wire logic   sck,
   input  wire logic   mosi,
   output logic        miso,
   // what arrived, for the bench
   output logic [31:0] hdr,
   output logic [31:0] last,
   output int          nbits
);
   logic [7:0] op, cnt, sr;
   logic [2:0] bitn;
   // host moves mosi in the same step as the rise; read the value that stood before it
   logic       mosi_d;
   assign #1 mosi_d = mosi;
   initial begin
      miso = 1'b0;
      nbits = 0;
   end
   // new frame: forget the previous one
   always @(negedge cs_n) begin
      nbits = 0;
      hdr = '0;
   end
   // a released line shows the inverse, never a held copy
   always @(posedge cs_n) miso = ~miso;
   // every bit taken on the rise
   always @(posedge sck) if (!cs_n) begin
      last = {last[30:0], mosi_d};
      if (nbits < 32) hdr[31 - nbits] = mosi_d;
      nbits++;
      if (nbits == 8) begin
         op = last[7:0];
         cnt = 8'h00;
         bitn = 3'd0;
      end
   end
   // answer launched on the fall, only once the opcode is complete
   always @(negedge sck) if (!cs_n && nbits >= 8) begin
      if (bitn == 3'd0) begin
         sr = op + cnt;
         cnt++;
      end
      miso = sr[7];
      sr = {sr[6:0], 1'b0};
      bitn++;
   end
endmodule : flash_model

/* File: tb/tb.sv */
// tb: self-checking bench for the flash host controller
// assumes flash_model on the pins; stimulus changes on CLK_SYS rise
`timescale 1ns/1ns
module tb;
   import flash_host_pkg::*;
   logic        clk = 0, rst = 1, cv = 0, m3 = 0, prog = 0, rw = 0, p528 = 0;
   logic        wv = 1, rrdy = 0, stall = 0, slow = 0, sck_q = 0, cs_q = 1, mosi_q = 0;
   logic        crdy, wrdy, rv, due, cs_n, sck, mosi, miso, rstn;
   logic [7:0]  op = 0, wd = 8'h5a, rd;
   logic [23:0] addr = 0, wl;
   logic [1:0]  na = 0;
   logic [2:0]  nd = 0;
   logic [15:0] nw = 0, nr = 0;
   logic [31:0] seed = 32'h21df2eff, hdr, last;
   logic [7:0]  ops [13] = '{8'he8, 8'h0b, 8'h03, 8'hd2, 8'hd4, 8'hd6, 8'hd1, 8'hd3,
                             8'h32, 8'h35, 8'h77, 8'hd7, 8'h9f};
   logic [7:0]  rq [$];
   int          nbits, bad_count = 0, check_count = 0, cyc = 0, since = 0, n0, ea;
   time         trel;

   flash_host dut_u (
      .CLK_SYS(clk), .RST(rst), .CMD_VALID(cv), .CMD_READY(crdy), .CMD_OPCODE(op),
      .CMD_ADDR(addr), .CMD_NADDR(na), .CMD_NDUMMY(nd), .CMD_NWRITE(nw), .CMD_NREAD(nr),
      .CMD_MODE3(m3), .CMD_PROG(prog), .CMD_REWRITE(rw), .PAGE_528(p528), .WR_VALID(wv),
      .WR_READY(wrdy), .WR_DATA(wd), .RD_VALID(rv), .RD_READY(rrdy), .RD_DATA(rd),
      .REWRITE_DUE(due), .FLASH_CS_N(cs_n), .FLASH_SCK(sck), .FLASH_MOSI(mosi),
      .FLASH_MISO(miso), .FLASH_RESET_N(rstn)
   );
   flash_model flash_u (
      .cs_n(cs_n), .sck(sck), .mosi(mosi), .miso(miso),
      .hdr(hdr), .last(last), .nbits(nbits)
   );

   initial begin
      forever #2 clk = ~clk;
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask : check

   task automatic end_of_test();
      if (bad_count == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_of_test

   // always lets one edge pass, so a just-taken command is not seen as idle
   task automatic wait_ready();
      int k;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (crdy !== 1'b1 && k < 20000);
      check(k < 20000, 1, "ready timeout");
      if (k >= 20000) end_of_test();
   endtask : wait_ready

   task automatic issue(input logic [7:0] o, input logic [1:0] a, input logic [2:0] d,
                        input logic [15:0] w, input logic [15:0] r);
      wait_ready();
      op <= o;
      na <= a;
      nd <= d;
      nw <= w;
      nr <= r;
      cv <= 1'b1;
      @(posedge clk);
      cv <= 1'b0;
   endtask : issue

   // expected answer byte n after the opcode is opcode plus n
   task automatic finish(input int ea, input logic [23:0] xa);
      int k;
      wait_ready();
      for (k = 0; k < 9000 && rq.size() < nr; k++) @(posedge clk);
      check(rq.size(), nr, "read count");
      check(nbits, 8 * (1 + ea + nd + nw + nr), "bit count");
      check(hdr[31:24], op, "opcode first");
      if (ea == 3) check(hdr[23:0], xa, "address bytes");
      for (k = 0; k < rq.size(); k++) check(rq[k], 8'(op + ea + nd + nw + k), "read byte");
   endtask : finish

   // streams, pin watch and watchdog on every system clock
   always @(posedge clk) begin
      cyc++;
      if (cv && crdy) rq.delete();
      if (rv && rrdy) rq.push_back(rd);
      if (wv && wrdy) begin
         wl <= {wl[15:0], wd};
         wd <= 8'(rnd());
      end
      rrdy <= !stall && rnd() % 4 != 0;
      // gaps in the write stream make the shifter wait before a byte
      wv <= rnd() % 2 != 0;
      if (!cs_n && !cs_q && mosi !== mosi_q) check(sck && !sck_q, 1, "data off rise");
      if (sck && !sck_q && !cs_n)
         check(since * CLK_NS * (slow ? SCK_SLOW_MHZ : SCK_FAST_MHZ) >= 1000, 1, "fast clock");
      if (!cs_n && cs_q) check(sck, m3, "idle clock level");
      since <= (sck && !sck_q) ? 1 : since + 1;
      sck_q <= sck;
      cs_q <= cs_n;
      mosi_q <= mosi;
      if (cyc > 90000) begin
         check(0, 1, "timeout");
         end_of_test();
      end
   end

   // select must already be idle when the flash leaves reset
   always @(posedge rstn) begin
      check(cs_n, 1, "select at reset release");
      check($time - trel >= T_RST_NS, 1, "reset pulse width");
   end

   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      trel = $time;
      // wear counter raised by the 78th program op
      prog <= 1'b1;
      for (int k = 1; k <= 78; k++) begin
         issue(8'h81, 0, 0, 0, 0);
         finish(0, 0);
         check(due, k >= REWRITE_SPACING, "rewrite flag");
      end
      // rewrite uses the page pointer, shifted by page layout
      prog <= 1'b0;
      rw <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         p528 <= k[0];
         issue(8'h58, 0, 0, 0, 0);
         finish(3, k ? 24'h000400 : 24'h000000);
         check(due, 0, "flag cleared");
      end
      rw <= 1'b0;
      addr <= 24'(rnd());
      issue(8'h84, 3, 0, 3, 0);
      finish(3, addr);
      check(last, {addr[7:0], wl}, "write bytes");
      // every read opcode twice, random mode, dummies and length
      for (int k = 0; k < 26; k++) begin
         addr <= 24'(rnd());
         m3 <= 1'(rnd());
         slow = ops[k % 13] inside {8'h03, 8'hd1, 8'hd3};
         ea = ops[k % 13] inside {8'hd7, 8'h9f} ? 0 : 3;
         issue(ops[k % 13], 3, 3'(rnd() % 3), 0, 16'(1 + rnd() % 4));
         finish(ea, addr);
      end
      // reader stalls: buffer fills and the clock must stop
      slow = 1'b0;
      stall = 1'b1;
      issue(8'hd2, 3, 4, 0, 40);
      repeat (2000) @(posedge clk);
      n0 = nbits;
      repeat (100) @(posedge clk);
      check(nbits, n0, "clock held while full");
      check({rv, crdy}, 2'b10, "data waiting, busy");
      stall = 1'b0;
      finish(3, addr);
      end_of_test();
   end
endmodule : tb
